/* File: rtl/lsrb_core.v */
// Register bank of the ambient light sensor: pointer, registers, conversion control
`timescale 1ns/1ps
`include "lsrb_regs.vh"

// Overview of operation
// RULE1 - Every register is sixteen bits wide.
// RULE2 - Result at 00h, configuration 01h, lower threshold 02h, upper threshold 03h.
// RULE3 - Read-only maker identity at 7Eh and part identity at 7Fh.
// RULE4 - Result is read-only and holds the last completed conversion.
// RULE5 - Result bits 15:12 hold exponent, bits 11:0 hold mantissa.
// RULE6 - Mantissa is unsigned straight binary from zero to full scale.
// RULE7 - Exponent codes 0 to 11, each step doubling one count's weight.
// RULE8 - Exponent reads zero when mask set and range is manual below 1100b.
// RULE9 - Result exponent and mantissa reset to zero.
// RULE10 - Configuration resets to C810h.
// RULE11 - A configuration write aborts any conversion in progress.
// RULE12 - After a configuration write, start a conversion if settings ask.
// RULE13 - Configuration field layout; bits 8 to 5 read-only, rest writable.
// RULE14 - Range select uses the same code mapping as the result exponent.
// RULE15 - Range code 1100b selects automatic range, reported in result exponent.
// RULE16 - Range select resets to the automatic code.
// RULE17 - Controller never programs range codes 1101b, 1110b or 1111b.
// RULE18 - First written byte sets the pointer, kept for reads until rewritten.
// RULE19 - Each word crosses as two bytes, most significant first.
// RULE20 - Writes to read-only fields or registers are ignored.
module lsrb_core #(
  parameter [15:0] MAKER_CODE = `LSRB_RST_MAKER,
  parameter [15:0] PART_CODE  = `LSRB_RST_PART
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        reset,
  // Byte port from the serial protocol engine
  input  wire        xfer_start,
  input  wire        xfer_is_read,
  input  wire        wr_byte_valid,
  input  wire [7:0]  wr_byte,
  input  wire        rd_byte_req,
  output wire [7:0]  rd_byte,
  output wire        rd_byte_valid,
  // Converter interface
  output wire        conv_start,
  output wire        conv_abort,
  input  wire        conv_active,
  input  wire        conv_done,
  input  wire [11:0] conv_mantissa,
  input  wire [3:0]  conv_exponent,
  input  wire        conv_overflow,
  // Limit comparator flags
  input  wire        high_flag_in,
  input  wire        low_flag_in,
  // Configuration to the rest of the sensor
  output wire [3:0]  range_select,
  output wire        conversion_time_sel,
  output wire [1:0]  conv_mode,
  output wire        latch_mode,
  output wire        interrupt_polarity,
  output wire        exponent_mask,
  output wire [1:0]  fault_count,
  output wire [15:0] lower_threshold,
  output wire [15:0] upper_threshold
);

  // Byte position within a transfer
  localparam [2:0] ST_PTR = 3'b001;
  localparam [2:0] ST_MSB = 3'b010;
  localparam [2:0] ST_LSB = 3'b100;

  // Reset image of the configuration word
  localparam [15:0] CFG_RST = `LSRB_RST_CONFIG;

  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [7:0]  pointer_ff;
  reg  [7:0]  msb_hold_ff;
  reg  [15:0] rd_word_ff;
  reg  [15:0] result_ff;
  reg  [3:0]  range_ff;
  reg         ctime_ff;
  reg  [1:0]  mode_ff;
  reg         latch_ff;
  reg         pol_ff;
  reg         emask_ff;
  reg  [1:0]  fault_ff;
  reg         ovf_ff;
  reg         ready_ff;
  reg         high_ff;
  reg         low_ff;
  reg  [15:0] lower_ff;
  reg  [15:0] upper_ff;

  // Registered outputs and their next values
  reg  [7:0]  rd_byte_ff;
  reg         rd_valid_ff;
  reg         conv_start_ff;
  reg         conv_abort_ff;
  reg         nxt_conv_start;
  reg         nxt_conv_abort;

  wire [15:0] wr_word;
  wire        word_commit;
  wire        cfg_write;
  wire [15:0] cfg_word;
  wire        first_rd_byte;
  wire        ptr_byte;
  wire        msb_byte;
  wire        lower_write;
  wire        upper_write;
  wire        done_taken;
  wire [1:0]  wr_mode;
  wire [15:0] rd_word_now;

  // Readback mux, shared by both byte halves
  function [15:0] reg_read;
    input [7:0]  ptr;
    input [15:0] res;
    input [15:0] cfg;
    input [15:0] lo;
    input [15:0] hi;
    begin
      case (ptr)
        `LSRB_ADDR_RESULT: reg_read = res; // RULE2
        `LSRB_ADDR_CONFIG: reg_read = cfg;
        `LSRB_ADDR_LOWER:  reg_read = lo;
        `LSRB_ADDR_UPPER:  reg_read = hi;
        // Identity words come from parameters, so no write can reach them
        `LSRB_ADDR_MAKER:  reg_read = MAKER_CODE; // RULE3
        `LSRB_ADDR_PART:   reg_read = PART_CODE;
        default:           reg_read = 16'h0000;
      endcase
    end
  endfunction

  // Exponent reported in the result word
  function [3:0] report_exp;
    input [3:0] rng;
    input       mask;
    input [3:0] conv_exp;
    begin
      if (rng == `LSRB_RANGE_AUTO) begin
        report_exp = conv_exp; // RULE15
      end else if (mask) begin
        report_exp = 4'h0; // RULE8
      end else begin
        report_exp = rng; // RULE14 RULE7
      end
    end
  endfunction

  // A strobe counts only in its byte position and never beside a transfer start
  function byte_take;
    input       strobe;
    input       start;
    input [2:0] cur;
    input [2:0] want;
    begin
      byte_take = strobe && !start && (cur == want);
    end
  endfunction

  // Committed word aimed at one register pointer
  function word_hit;
    input       commit;
    input [7:0] ptr;
    input [7:0] addr;
    begin
      word_hit = commit && (ptr == addr);
    end
  endfunction

  assign cfg_word = {range_ff, ctime_ff, mode_ff, ovf_ff, ready_ff, high_ff, low_ff,
                     latch_ff, pol_ff, emask_ff, fault_ff}; // RULE13 RULE1
  assign wr_word     = {msb_hold_ff, wr_byte}; // RULE19
  assign word_commit = byte_take(wr_byte_valid, xfer_start, state_ff, ST_LSB);
  assign ptr_byte    = byte_take(wr_byte_valid, xfer_start, state_ff, ST_PTR);
  assign msb_byte    = byte_take(wr_byte_valid, xfer_start, state_ff, ST_MSB);
  assign cfg_write   = word_hit(word_commit, pointer_ff, `LSRB_ADDR_CONFIG);
  assign lower_write = word_hit(word_commit, pointer_ff, `LSRB_ADDR_LOWER);
  assign upper_write = word_hit(word_commit, pointer_ff, `LSRB_ADDR_UPPER);
  assign first_rd_byte = byte_take(rd_byte_req, xfer_start, state_ff, ST_MSB);
  assign done_taken  = conv_done && !cfg_write;
  assign wr_mode     = wr_word[`LSRB_CFG_MODE_MSB:`LSRB_CFG_MODE_LSB];
  // The LSB of a read comes from this same snapshot
  assign rd_word_now = reg_read(pointer_ff, result_ff, cfg_word, lower_ff, upper_ff);

  // Byte sequencing: write is pointer, MSB, LSB; read is MSB, LSB
  always @* begin
    nxt_state = state_ff;
    if (xfer_start) begin
      nxt_state = xfer_is_read ? ST_MSB : ST_PTR; // RULE18
    end else begin
      case (state_ff)
        ST_PTR: begin
          if (wr_byte_valid) begin
            nxt_state = ST_MSB;
          end
        end
        ST_MSB: begin
          if (wr_byte_valid || rd_byte_req) begin
            nxt_state = ST_LSB;
          end
        end
        ST_LSB: begin
          if (wr_byte_valid || rd_byte_req) begin
            nxt_state = ST_MSB;
          end
        end
        default: nxt_state = ST_MSB;
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      state_ff    <= ST_MSB;
      pointer_ff  <= 8'h00;
      msb_hold_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      if (ptr_byte) begin
        pointer_ff <= wr_byte; // RULE18
      end
      if (msb_byte) begin
        msb_hold_ff <= wr_byte; // RULE19
      end
    end
  end

  // Read path; word is captured at its first byte so both halves match
  always @(posedge core_clk) begin
    if (reset) begin
      rd_word_ff  <= 16'h0000;
      rd_byte_ff  <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_byte_req && !xfer_start;
      if (first_rd_byte) begin
        rd_word_ff <= rd_word_now;
        rd_byte_ff <= rd_word_now[15:8];
      end else if (rd_byte_req && !xfer_start) begin
        rd_byte_ff <= rd_word_ff[7:0]; // RULE19
      end
    end
  end

  // Writable registers; read-only pointers fall through untouched
  always @(posedge core_clk) begin
    if (reset) begin
      range_ff <= CFG_RST[`LSRB_CFG_RANGE_MSB:`LSRB_CFG_RANGE_LSB]; // RULE10 RULE16
      ctime_ff <= CFG_RST[`LSRB_CFG_CTIME];
      mode_ff  <= CFG_RST[`LSRB_CFG_MODE_MSB:`LSRB_CFG_MODE_LSB];
      latch_ff <= CFG_RST[`LSRB_CFG_LATCH];
      pol_ff   <= CFG_RST[`LSRB_CFG_POL];
      emask_ff <= CFG_RST[`LSRB_CFG_EMASK];
      fault_ff <= CFG_RST[`LSRB_CFG_FAULT_MSB:`LSRB_CFG_FAULT_LSB];
      lower_ff <= `LSRB_RST_LOWER;
      upper_ff <= `LSRB_RST_UPPER;
    end else begin
      if (cfg_write) begin
        // Bits 8 to 5 are not taken from the bus
        range_ff <= wr_word[`LSRB_CFG_RANGE_MSB:`LSRB_CFG_RANGE_LSB]; // RULE13 RULE20
        ctime_ff <= wr_word[`LSRB_CFG_CTIME];
        mode_ff  <= wr_word[`LSRB_CFG_MODE_MSB:`LSRB_CFG_MODE_LSB];
        latch_ff <= wr_word[`LSRB_CFG_LATCH];
        pol_ff   <= wr_word[`LSRB_CFG_POL];
        emask_ff <= wr_word[`LSRB_CFG_EMASK];
        fault_ff <= wr_word[`LSRB_CFG_FAULT_MSB:`LSRB_CFG_FAULT_LSB];
      end else if (conv_done && mode_ff == `LSRB_MODE_SINGLE) begin
        mode_ff <= `LSRB_MODE_OFF;
      end
      // Thresholds are plain storage; the comparison lives elsewhere
      if (lower_write) begin
        lower_ff <= wr_word;
      end
      if (upper_write) begin
        upper_ff <= wr_word;
      end
    end
  end

  // Result and status; a done that coincides with a config write is the
  // aborted conversion, so it is dropped
  always @(posedge core_clk) begin
    if (reset) begin
      result_ff <= `LSRB_RST_RESULT; // RULE9
      ovf_ff    <= 1'b0;
      ready_ff  <= 1'b0;
      high_ff   <= 1'b0;
      low_ff    <= 1'b0;
    end else begin
      high_ff <= high_flag_in;
      low_ff  <= low_flag_in;
      if (done_taken) begin
        result_ff <= {report_exp(range_ff, emask_ff, conv_exponent),
                      conv_mantissa}; // RULE4 RULE5 RULE6
        ovf_ff    <= conv_overflow;
        ready_ff  <= 1'b1;
      end else if (first_rd_byte && pointer_ff == `LSRB_ADDR_CONFIG) begin
        // Reading configuration acknowledges the ready flag; a new result wins
        ready_ff <= 1'b0;
      end
    end
  end

  // Conversion control; abort only matters while the converter runs
  always @* begin
    nxt_conv_abort = cfg_write && conv_active; // RULE11
    nxt_conv_start = 1'b0;
    if (cfg_write) begin
      // A config write outranks a done in the same cycle
      nxt_conv_start = (wr_mode != `LSRB_MODE_OFF); // RULE12
    end else if (done_taken && mode_ff[1]) begin
      nxt_conv_start = 1'b1;
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      conv_start_ff <= 1'b0;
      conv_abort_ff <= 1'b0;
    end else begin
      conv_start_ff <= nxt_conv_start;
      conv_abort_ff <= nxt_conv_abort;
    end
  end

  assign range_select        = range_ff;
  assign conversion_time_sel = ctime_ff;
  assign conv_mode           = mode_ff;
  assign latch_mode          = latch_ff;
  assign interrupt_polarity  = pol_ff;
  assign exponent_mask       = emask_ff;
  assign fault_count         = fault_ff;
  assign lower_threshold     = lower_ff;
  assign upper_threshold     = upper_ff;

  // Outputs
  assign rd_byte             = rd_byte_ff;
  assign rd_byte_valid       = rd_valid_ff;
  assign conv_start          = conv_start_ff;
  assign conv_abort          = conv_abort_ff;

endmodule

/* File: rtl/lsrb_regs.vh */
// Register map, field positions and reset values of the light sensor register bank
`ifndef LSRB_REGS_VH
`define LSRB_REGS_VH

// Register pointer values
`define LSRB_ADDR_RESULT     8'h00
`define LSRB_ADDR_CONFIG     8'h01
`define LSRB_ADDR_LOWER      8'h02
`define LSRB_ADDR_UPPER      8'h03
`define LSRB_ADDR_MAKER      8'h7E
`define LSRB_ADDR_PART       8'h7F

// Result fields
`define LSRB_RES_EXP_MSB     15
`define LSRB_RES_EXP_LSB     12
`define LSRB_RES_MAN_MSB     11
`define LSRB_RES_MAN_LSB     0

// Configuration fields
`define LSRB_CFG_RANGE_MSB   15
`define LSRB_CFG_RANGE_LSB   12
`define LSRB_CFG_CTIME       11
`define LSRB_CFG_MODE_MSB    10
`define LSRB_CFG_MODE_LSB    9
`define LSRB_CFG_OVF         8
`define LSRB_CFG_READY       7
`define LSRB_CFG_HIGH        6
`define LSRB_CFG_LOW         5
`define LSRB_CFG_LATCH       4
`define LSRB_CFG_POL         3
`define LSRB_CFG_EMASK       2
`define LSRB_CFG_FAULT_MSB   1
`define LSRB_CFG_FAULT_LSB   0

// Codes
`define LSRB_RANGE_AUTO      4'hC
`define LSRB_MODE_OFF        2'h0
`define LSRB_MODE_SINGLE     2'h1

// Reset values
`define LSRB_RST_RESULT      16'h0000
`define LSRB_RST_CONFIG      16'hC810
`define LSRB_RST_LOWER       16'h0000
`define LSRB_RST_UPPER       16'hFFFF
`define LSRB_RST_MAKER       16'h1234  // Arbitrary value
`define LSRB_RST_PART        16'h5678  // Arbitrary value

`endif

/* File: verification/lsrb_monitor.sv */
// Port assertions for the light sensor register bank
`timescale 1ns/1ps
module lsrb_monitor (
  // Clock and reset
  input wire        core_clk,
  input wire        reset,
  // Byte port
  input wire        wr_byte_valid,
  input wire        rd_byte_req,
  input wire        rd_byte_valid,
  // Converter
  input wire        conv_start,
  input wire        conv_abort,
  input wire        conv_active,
  input wire        conv_done,
  input wire [1:0]  conv_mode,
  // Settings
  input wire [3:0]  range_select,
  input wire        exponent_mask,
  input wire [15:0] lower_threshold,
  input wire [15:0] upper_threshold
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_read_answer: assert property (rd_byte_req |=> rd_byte_valid)
    else $error("read byte late");
  a_reset_values: assert property ($fell(reset) |-> range_select == 4'hC
    && conv_mode == 2'h0 && lower_threshold == 16'h0000 && upper_threshold == 16'hFFFF)
    else $error("bad reset values");
  a_single_end: assert property (conv_done && conv_mode == 2'h1 && !wr_byte_valid
    |=> conv_mode == 2'h0) else $error("single mode kept");
  a_cont_restart: assert property (conv_done && conv_mode[1] && !wr_byte_valid
    |=> conv_start) else $error("no restart");
  a_abort_cause: assert property (conv_abort |->
    $past(wr_byte_valid) && $past(conv_active)) else $error("stray abort");
  a_start_cause: assert property (conv_start |->
    $past(wr_byte_valid) || $past(conv_done)) else $error("stray start");
  a_cfg_hold: assert property (!$past(reset) && !$past(wr_byte_valid) |->
    $stable({range_select, exponent_mask})) else $error("config moved");
  a_thr_hold: assert property (!$past(reset) && !$past(wr_byte_valid) |->
    $stable({lower_threshold, upper_threshold})) else $error("threshold moved");
  c_abort: cover property (conv_abort);
  c_restart: cover property (conv_done && conv_mode[1]);
  c_read: cover property (rd_byte_valid);
endmodule

bind lsrb_core lsrb_monitor u_mon (.core_clk(core_clk), .reset(reset),
  .wr_byte_valid(wr_byte_valid), .rd_byte_req(rd_byte_req), .rd_byte_valid(rd_byte_valid),
  .conv_start(conv_start), .conv_abort(conv_abort), .conv_active(conv_active),
  .conv_done(conv_done), .conv_mode(conv_mode), .range_select(range_select),
  .exponent_mask(exponent_mask), .lower_threshold(lower_threshold),
  .upper_threshold(upper_threshold));

/* File: verification/lsrb_host_model.sv */
// Host byte engine model: frames register writes and reads
`timescale 1ns/1ps
module lsrb_host_model (
  // Clock
  input  wire       core_clk,
  // Byte port towards the bank
  output reg        xfer_start,
  output reg        xfer_is_read,
  output reg        wr_byte_valid,
  output reg  [7:0] wr_byte,
  output reg        rd_byte_req,
  input  wire [7:0] rd_byte,
  input  wire       rd_byte_valid
);
  initial {xfer_start, xfer_is_read, wr_byte_valid, rd_byte_req, wr_byte} = 12'h05A;
  task xfer(input logic rd);
    @(negedge core_clk);
    xfer_start = 1'h1;
    xfer_is_read = rd;
    @(negedge core_clk);
    xfer_start = 1'h0;
  endtask
  task put(input logic [7:0] b);
    wr_byte = b;
    wr_byte_valid = 1'h1;
    @(negedge core_clk);
  endtask
  task wr_reg(input logic [7:0] ptr, input logic [15:0] val, input bit data = 1);
    xfer(1'h0);
    put(ptr);
    if (data) put(val[15:8]);
    if (data) put(val[7:0]);
    wr_byte_valid = 1'h0;
    // Flip the released byte so a stale value never passes as data
    wr_byte = ~wr_byte;
  endtask
  task get(output logic [7:0] b);
    rd_byte_req = 1'h1;
    @(negedge core_clk);
    repeat (2) if (rd_byte_valid !== 1'h1) @(negedge core_clk);
    b = rd_byte_valid ? rd_byte : 8'hXX;
  endtask
  task rd_reg(output logic [15:0] val);
    logic [7:0] hi, lo;
    xfer(1'h1);
    get(hi);
    get(lo);
    rd_byte_req = 1'h0;
    val = {hi, lo};
  endtask
endmodule

/* File: verification/tb_light_sensor_register_bank.sv */
// Self-checking bench of the light sensor register bank with a register model
`timescale 1ns/1ps
module tb_light_sensor_register_bank;
  localparam [15:0] MAKER = 16'hA5C3;  // Arbitrary value
  localparam [15:0] PART  = 16'h3C5A;  // Arbitrary value
  logic        core_clk = 1'h0;
  logic        reset = 1'h1;
  logic        xfer_start, xfer_is_read, wr_byte_valid, rd_byte_req, rd_byte_valid;
  logic [7:0]  wr_byte, rd_byte;
  logic        conv_start, conv_abort, conv_active, conv_done, conv_overflow, emask;
  logic        high_flag_in, low_flag_in, m_ovf, m_rdy, ctime_o, latch_o, pol_o;
  logic [11:0] conv_mantissa;
  logic [3:0]  conv_exponent, range_select;
  logic [1:0]  conv_mode, fault_o;
  logic [15:0] lower_threshold, upper_threshold, m_cfg, m_res, v;
  logic [31:0] seed = 32'h9A02;
  integer      failures = 0;
  integer      num_checks = 0;
  integer      k;

  always #5 core_clk = ~core_clk;

  lsrb_core #(.MAKER_CODE(MAKER), .PART_CODE(PART)) dut_u (.core_clk(core_clk),
    .reset(reset), .xfer_start(xfer_start), .xfer_is_read(xfer_is_read),
    .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte), .rd_byte_req(rd_byte_req),
    .rd_byte(rd_byte), .rd_byte_valid(rd_byte_valid), .conv_start(conv_start),
    .conv_abort(conv_abort), .conv_active(conv_active), .conv_done(conv_done),
    .conv_mantissa(conv_mantissa), .conv_exponent(conv_exponent),
    .conv_overflow(conv_overflow), .high_flag_in(high_flag_in), .low_flag_in(low_flag_in),
    .range_select(range_select), .conversion_time_sel(ctime_o), .conv_mode(conv_mode),
    .latch_mode(latch_o), .interrupt_polarity(pol_o), .exponent_mask(emask),
    .fault_count(fault_o),
    .lower_threshold(lower_threshold), .upper_threshold(upper_threshold));
  lsrb_host_model h (.core_clk(core_clk), .xfer_start(xfer_start),
    .xfer_is_read(xfer_is_read), .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte),
    .rd_byte_req(rd_byte_req), .rd_byte(rd_byte), .rd_byte_valid(rd_byte_valid));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] cfg_exp();
    return {m_cfg[15:9], m_ovf, m_rdy, high_flag_in, low_flag_in, m_cfg[4:0]};
  endfunction
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) failures++;
    if (got !== exp) $display("wrong value %s expected %h seen %h", what, exp, got);
  endtask
  task chkp(input string what, input logic exp, input logic got);
    chk(what, {15'h0000, exp}, {15'h0000, got});
  endtask
  task rd(input logic [7:0] ptr, input logic [15:0] exp, input string what);
    logic [15:0] got;
    h.wr_reg(ptr, 16'h0000, 0);
    h.rd_reg(got);
    chk(what, exp, got);
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #900000;
    failures++;
    give_verdict;
  end

  initial begin
    {conv_active, conv_done, conv_overflow, high_flag_in, low_flag_in} = 5'h00;
    {conv_exponent, conv_mantissa, m_ovf, m_rdy} = 18'h00000;
    repeat (6) @(negedge core_clk);
    reset = 1'h0;
    m_cfg = 16'hC810;
    rd(8'h01, cfg_exp(), "config reset");
    rd(8'h00, 16'h0000, "result reset");
    rd(8'h02, 16'h0000, "lower reset");
    rd(8'h03, 16'hFFFF, "upper reset");
    rd(8'h7E, MAKER, "maker id");
    rd(8'h7F, PART, "part id");
    rd(8'h40, 16'h0000, "unmapped");
    chkp("auto range", 1'h1, range_select === 4'hC);
    $display("test reset values done");
    for (k = 0; k < 3; k++) begin
      v = rnd();
      h.wr_reg(8'h02, v);
      h.wr_reg(8'h03, ~v);
      h.wr_reg(8'h00, v);
      h.wr_reg(8'h7F, v);
      chk("upper out", ~v, upper_threshold);
      rd(8'h02, v, "lower");
      rd(8'h00, 16'h0000, "result kept");
      rd(8'h7F, PART, "part kept");
      h.rd_reg(m_res);
      chk("pointer kept", PART, m_res);
    end
    $display("test thresholds done");
    for (k = 0; k < 6; k++) begin
      v = rnd();
      {high_flag_in, low_flag_in} = k[1:0];
      v[15:12] = (k == 0 || k == 3) ? 4'hC : v[15:12] % 4'hC;
      v[2] = (k == 1);
      v[10:9] = (k == 3) ? 2'h2 : 2'h1;
      conv_active = (k != 0);
      h.wr_reg(8'h01, v);
      m_cfg = v & 16'hFE1F;
      chkp("abort", k != 0, conv_abort);
      chkp("start", 1'h1, conv_start);
      chk("range out", {12'h000, v[15:12]}, {12'h000, range_select});
      chk("fields out", {10'h000, v[11], v[4:0]},
          {10'h000, ctime_o, latch_o, pol_o, emask, fault_o});
      chk("mode out", {14'h0000, v[10:9]}, {14'h0000, conv_mode});
      void'(rnd());
      {conv_overflow, conv_exponent, conv_mantissa} = seed[16:0];
      conv_exponent = conv_exponent % 4'hC;
      conv_active = 1'h0;
      conv_done = 1'h1;
      @(negedge core_clk);
      conv_done = 1'h0;
      chkp("restart", k == 3, conv_start);
      m_res = {(m_cfg[15:12] == 4'hC) ? conv_exponent : (m_cfg[2] ? 4'h0 : m_cfg[15:12]),
               conv_mantissa};
      {m_ovf, m_rdy} = {conv_overflow, 1'h1};
      if (k != 3) m_cfg[10:9] = 2'h0;
      rd(8'h00, m_res, "result");
      rd(8'h01, cfg_exp(), "config after done");
      m_rdy = 1'h0;
      rd(8'h01, cfg_exp(), "ready cleared");
    end
    conv_active = 1'h1;
    h.wr_reg(8'h01, 16'hC810);
    chkp("abort on stop", 1'h1, conv_abort);
    chkp("no start", 1'h0, conv_start);
    conv_active = 1'h0;
    $display("test conversions done");
    give_verdict;
  end
endmodule
